// File: hdl/lasp_pkg.sv
// Package for the LCD active and smart panel output port.
// Assumes a system clock of 25 MHz and a pixel-link clock of its own.
package lasp_pkg;

  // Operating modes of the panel port
  typedef enum logic [1:0] {
    LASP_MODE_OFF    = 2'h0,
    LASP_MODE_ACT16  = 2'h1,
    LASP_MODE_ACT18  = 2'h3,
    LASP_MODE_SMART  = 2'h2
  } lasp_mode_type;

  // Smart panel transfer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    LASP_SM_IDLE  = 3'h0,
    LASP_SM_SETUP = 3'h1,
    LASP_SM_STRB  = 3'h3,
    LASP_SM_HOLD  = 3'h2,
    LASP_SM_RDSTB = 3'h6,
    LASP_SM_RDEND = 3'h7
  } lasp_sm_type;

  // Widths
  localparam int LASP_DATA_W  = 18;
  localparam int LASP_TIMER_W = 12;

  // Field positions inside an 18-bit source pixel (6:6:6)
  localparam int LASP_R6_LSB = 12;
  localparam int LASP_G6_LSB = 6;
  localparam int LASP_B6_LSB = 0;
  // Field positions on the 16-bit data word (5:6:5)
  localparam int LASP_R5_LSB = 11;
  localparam int LASP_G5_LSB = 5;
  localparam int LASP_B5_LSB = 0;

  // Smart panel byte order selections
  localparam logic [1:0] LASP_ORD_RGB = 2'h0;
  localparam logic [1:0] LASP_ORD_BGR = 2'h1;
  localparam logic [1:0] LASP_ORD_GRB = 2'h2;
  localparam logic [1:0] LASP_ORD_BRG = 2'h3;

  // Number of bus transfers per smart-panel pixel
  localparam logic [1:0] LASP_SMART_BYTES = 2'h3;

  // Reset values
  localparam logic [17:0] LASP_DATA_RST = 18'h00000;
  localparam logic [11:0] LASP_TIMER_RST = 12'h000;

endpackage

// File: hdl/lasp_port.sv
// Output side of an LCD controller: active panel timing and smart panel bus.
// Assumes pixels arrive from frame logic on pix_clk, one per pix_take strobe;
// pin logic runs on pix_clk, with a pix_rst synchronous to that clock.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Active modes put one pixel per pixel clock on the data lines, raw only in 18-bit mode.
// - 16-bit active mode drives a 16-bit word, usually 5:6:5.
// - Red sits on bits 15..11, green 10..5, blue 4..0, MSB highest.
// - 12-bit panels use 16-bit mode, wired to bits 15-12, 10-7, 4-1.
// - 18-bit active mode drives 18 lines, six bits per colour.
// - Pixel clock is output in active mode; panel samples data on it.
// - Line clock pin doubles as horizontal sync in active mode.
// - Frame clock pin doubles as vertical sync in active mode.
// - Bias pin is data enable; panel latches only while it is high.
// - Alternate pin ordering bit keeps overlay pixels on expected lines.
// - Smart mode uses lower eight lines, three transfers per pixel.
// - Smart mode pixel clock pin is the write strobe.
// - Smart mode line clock pin selects command or data.
// - Smart mode frame clock pin is the read strobe.
// - Smart mode drives a chip select framing each panel access.
module lasp_port (
  // System side
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sys_ce,
  // Configuration, sys_clk levels
  input  wire lasp_pkg::lasp_mode_type cfg_mode,
  input  wire logic                  alt_data_pin_order,
  input  wire logic [1:0]            cfg_byte_order,
  input  wire logic [11:0]           cfg_h_active,
  input  wire logic [11:0]           cfg_h_blank,
  input  wire logic [11:0]           cfg_v_active,
  input  wire logic [11:0]           cfg_v_blank,
  // Smart panel command request, sys_clk
  input  wire logic                  cmd_valid,
  input  wire logic                  cmd_is_read,
  input  wire logic                  cmd_is_cmd,
  input  wire logic [7:0]            cmd_byte,
  output logic                       cmd_ready,
  output logic [7:0]                 rd_byte,
  output logic                       rd_valid,
  output logic                       refresh_sync,
  // Link clock
  input  wire logic                  pix_clk,
  input  wire logic                  pix_rst,
  // Pixel source, pix_clk domain
  input  wire logic [17:0]           pix_data,
  output logic                       pix_take,
  // Panel pins
  output logic [17:0]                lcd_data_lines,
  output logic [17:0]                lcd_data_oe,
  input  wire logic [7:0]            lcd_data_in,
  output logic                       pixel_clock_wr_pin,
  output logic                       line_clock_cmd_pin,
  output logic                       frame_clock_read_pin,
  output logic                       bias_de_pin,
  output logic                       panel_cs_n,
  input  wire logic                  panel_vsync_in
);
  import lasp_pkg::*;

  // Configuration crossed into link domain; software holds it static per frame
  logic [53:0] cfg_bus_s;
  logic [53:0] cfg_bus_p;
  assign cfg_bus_s = {cfg_mode, alt_data_pin_order, cfg_byte_order, cfg_h_active,
                      cfg_h_blank, cfg_v_active, cfg_v_blank, 1'b0};
  lasp_sync #(.WIDTH(54)) u_cfg_sync (
    .clk  (pix_clk),
    .rst  (pix_rst),
    .d_in (cfg_bus_s),
    .q_out(cfg_bus_p)
  );
  lasp_mode_type p_mode;
  logic          p_alt;
  logic [1:0]    p_order;
  logic [11:0]   p_ha;
  logic [11:0]   p_hb;
  logic [11:0]   p_va;
  logic [11:0]   p_vb;
  assign p_mode  = lasp_mode_type'(cfg_bus_p[53:52]);
  assign p_alt   = cfg_bus_p[51];
  assign p_order = cfg_bus_p[50:49];
  assign p_ha    = cfg_bus_p[48:37];
  assign p_hb    = cfg_bus_p[36:25];
  assign p_va    = cfg_bus_p[24:13];
  assign p_vb    = cfg_bus_p[12:1];

  logic active_mode;
  logic smart_mode;
  assign active_mode = (p_mode == LASP_MODE_ACT16) || (p_mode == LASP_MODE_ACT18);
  assign smart_mode  = (p_mode == LASP_MODE_SMART);

  // Link-domain clock enable: level crossed from sys side
  logic ce_p;
  lasp_sync #(.WIDTH(1)) u_ce_sync (
    .clk  (pix_clk),
    .rst  (pix_rst),
    .d_in (sys_ce),
    .q_out(ce_p)
  );

  // Raster counters for active mode
  logic [11:0] h_cnt_reg;
  logic [11:0] v_cnt_reg;
  logic        h_end;
  logic        v_end;
  assign h_end = (h_cnt_reg == p_ha + p_hb - 12'h001);
  assign v_end = (v_cnt_reg == p_va + p_vb - 12'h001);
  always_ff @(posedge pix_clk) begin
    if (pix_rst || !active_mode) begin
      h_cnt_reg <= LASP_TIMER_RST;
      v_cnt_reg <= LASP_TIMER_RST;
    end else if (ce_p) begin
      h_cnt_reg <= h_end ? LASP_TIMER_RST : h_cnt_reg + 12'h001;
      if (h_end) begin
        v_cnt_reg <= v_end ? LASP_TIMER_RST : v_cnt_reg + 12'h001;
      end
    end
  end

  logic in_active;
  assign in_active = (h_cnt_reg < p_ha) && (v_cnt_reg < p_va);
  // One pixel consumed per clock while visible
  assign pix_take = active_mode && ce_p && in_active;

  // Active-mode pixel word: 18 bits raw, or 5:6:5 from the 6:6:6 source
  logic [17:0] act_word;
  always_comb begin
    act_word = pix_data;
    if (p_mode == LASP_MODE_ACT16) begin
      act_word = 18'h00000;
      // Red 15..11, green 10..5, blue 4..0
      act_word[LASP_R5_LSB +: 5] = pix_data[LASP_R6_LSB+1 +: 5];
      act_word[LASP_G5_LSB +: 6] = pix_data[LASP_G6_LSB +: 6];
      act_word[LASP_B5_LSB +: 5] = pix_data[LASP_B6_LSB+1 +: 5];
      // Overlay-safe ordering: swap bytes of the 16-bit word
      if (p_alt) begin
        act_word[15:0] = {act_word[7:0], act_word[15:8]};
      end
    end
  end

  // Active outputs; data held while enable low
  logic [17:0] act_data_reg;
  logic        de_reg;
  logic        hs_reg;
  logic        vs_reg;
  always_ff @(posedge pix_clk) begin
    if (pix_rst) begin
      act_data_reg <= LASP_DATA_RST;
      de_reg       <= 1'b0;
      hs_reg       <= 1'b0;
      vs_reg       <= 1'b0;
    end else if (ce_p) begin
      de_reg <= pix_take;
      hs_reg <= active_mode && h_end;
      vs_reg <= active_mode && h_end && v_end;
      if (pix_take) begin
        act_data_reg <= act_word;
      end
    end
  end

  // Smart panel command crossing: req/ack handshake with data held stable
  logic       req_s_reg;
  logic       ack_p;
  logic       ack_s;
  logic       req_p;
  logic [9:0] cmd_hold_reg;
  assign cmd_ready = (req_s_reg == ack_s);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_s_reg    <= 1'b0;
      cmd_hold_reg <= 10'h000;
    end else if (sys_ce && cmd_valid && cmd_ready) begin
      req_s_reg    <= ~req_s_reg;
      cmd_hold_reg <= {cmd_is_read, cmd_is_cmd, cmd_byte};
    end
  end
  lasp_sync #(.WIDTH(1)) u_req_sync (
    .clk  (pix_clk),
    .rst  (pix_rst),
    .d_in (req_s_reg),
    .q_out(req_p)
  );

  // Smart panel pixel byte counter and order
  logic [1:0] byte_idx_reg;
  logic [7:0] pix_byte;
  logic [1:0] sel;
  always_comb begin
    // Index 0 = red, 1 = green, 2 = blue
    case (p_order)
      LASP_ORD_RGB: sel = byte_idx_reg;
      LASP_ORD_BGR: sel = 2'h2 - byte_idx_reg;
      LASP_ORD_GRB: sel = (byte_idx_reg == 2'h0) ? 2'h1 : (byte_idx_reg == 2'h1) ? 2'h0 : 2'h2;
      LASP_ORD_BRG: sel = (byte_idx_reg == 2'h0) ? 2'h2 : byte_idx_reg - 2'h1;
      default:      sel = byte_idx_reg;
    endcase
    case (sel)
      2'h0:    pix_byte = {pix_data[LASP_R6_LSB +: 6], 2'h0};
      2'h1:    pix_byte = {pix_data[LASP_G6_LSB +: 6], 2'h0};
      default: pix_byte = {pix_data[LASP_B6_LSB +: 6], 2'h0};
    endcase
  end

  // Smart panel bus state machine
  lasp_sm_type sm_reg;
  logic        ack_p_reg;
  logic        is_cmd_reg;
  logic        is_pix_reg;
  logic [7:0]  sm_data_reg;
  logic [7:0]  rd_cap_reg;
  logic        smart_pix_take;
  logic        pix_avail;
  assign ack_p          = ack_p_reg;
  assign pix_avail      = smart_mode && ce_p;
  assign smart_pix_take = (sm_reg == LASP_SM_HOLD) && is_pix_reg && (byte_idx_reg == LASP_SMART_BYTES - 2'h1);
  always_ff @(posedge pix_clk) begin
    if (pix_rst || !smart_mode) begin
      sm_reg       <= LASP_SM_IDLE;
      ack_p_reg    <= 1'b0;
      is_cmd_reg   <= 1'b0;
      is_pix_reg   <= 1'b0;
      sm_data_reg  <= 8'h00;
      rd_cap_reg   <= 8'h00;
      byte_idx_reg <= 2'h0;
    end else if (ce_p) begin
      case (sm_reg)
        LASP_SM_IDLE: begin
          if (req_p != ack_p_reg) begin
            // Commands take priority over pixel streaming
            is_cmd_reg  <= cmd_hold_reg[8];
            is_pix_reg  <= 1'b0;
            sm_data_reg <= cmd_hold_reg[7:0];
            sm_reg      <= cmd_hold_reg[9] ? LASP_SM_RDSTB : LASP_SM_SETUP;
          end else if (pix_avail) begin
            is_cmd_reg  <= 1'b0;
            is_pix_reg  <= 1'b1;
            sm_data_reg <= pix_byte;
            sm_reg      <= LASP_SM_SETUP;
          end
        end
        LASP_SM_SETUP: sm_reg <= LASP_SM_STRB;
        LASP_SM_STRB:  sm_reg <= LASP_SM_HOLD;
        LASP_SM_HOLD: begin
          sm_reg <= LASP_SM_IDLE;
          if (is_pix_reg) begin
            // Three transfers per pixel
            byte_idx_reg <= (byte_idx_reg == LASP_SMART_BYTES - 2'h1) ? 2'h0 : byte_idx_reg + 2'h1;
          end else begin
            ack_p_reg <= ~ack_p_reg;
          end
        end
        LASP_SM_RDSTB: begin
          rd_cap_reg <= lcd_data_in;
          sm_reg     <= LASP_SM_RDEND;
        end
        LASP_SM_RDEND: begin
          ack_p_reg <= ~ack_p_reg;
          sm_reg    <= LASP_SM_IDLE;
        end
        default: sm_reg <= LASP_SM_IDLE;
      endcase
    end
  end

  // Third smart byte is flagged but unused; the pixel source does not advance in smart mode
  logic unused_take;
  assign unused_take = smart_pix_take;

  // Ack and read data back to sys_clk; read byte stable before ack toggles
  lasp_sync #(.WIDTH(1)) u_ack_sync (
    .clk  (sys_clk),
    .rst  (sys_rst),
    .d_in (ack_p),
    .q_out(ack_s)
  );
  logic ack_s_d_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_s_d_reg <= 1'b0;
      rd_byte     <= 8'h00;
      rd_valid    <= 1'b0;
    end else if (sys_ce) begin
      ack_s_d_reg <= ack_s;
      rd_valid    <= (ack_s != ack_s_d_reg) && cmd_hold_reg[9];
      if (ack_s != ack_s_d_reg) begin
        rd_byte <= rd_cap_reg;
      end
    end
  end

  // Panel refresh sync pin into system domain
  lasp_sync #(.WIDTH(1)) u_vs_sync (
    .clk  (sys_clk),
    .rst  (sys_rst),
    .d_in (panel_vsync_in),
    .q_out(refresh_sync)
  );

  // Pin multiplexing by mode
  logic sm_access;
  assign sm_access = (sm_reg != LASP_SM_IDLE);
  always_comb begin
    lcd_data_lines       = act_data_reg;
    lcd_data_oe          = active_mode ? 18'h3FFFF : 18'h00000;
    pixel_clock_wr_pin   = active_mode ? ~pix_clk : 1'b0;
    line_clock_cmd_pin   = hs_reg;
    frame_clock_read_pin = vs_reg;
    bias_de_pin          = de_reg;
    panel_cs_n           = 1'b1;
    if (smart_mode) begin
      lcd_data_lines       = {10'h000, sm_data_reg};
      lcd_data_oe          = (sm_access && (sm_reg != LASP_SM_RDSTB) && (sm_reg != LASP_SM_RDEND)) ?
                             18'h000FF : 18'h00000;
      pixel_clock_wr_pin   = (sm_reg == LASP_SM_STRB);
      line_clock_cmd_pin   = ~is_cmd_reg;
      frame_clock_read_pin = (sm_reg == LASP_SM_RDSTB);
      bias_de_pin          = 1'b0;
      panel_cs_n           = ~sm_access;
    end
  end

endmodule
`default_nettype wire

// File: hdl/lasp_sync.sv
// Two-flop level synchroniser for control levels entering a domain; held command and read bytes cross without it.
// Assumes the source is a level that holds for at least two destination clocks.
`timescale 1ns/10ps
`default_nettype none
module lasp_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  // First flop feeds only the second one
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_out    <= '0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: tb/lasp_panel_model.sv
// Smart panel model: bus slave with write log, read reply and refresh sync.
// Assumes the port frames each access with chip select low.
`timescale 1ns/10ps
`default_nettype none
module lasp_panel_model (
  // Panel timing
  input wire logic        pix_clk,
  // Pins from the port
  input wire logic [17:0] lcd_data_lines,
  input wire logic [17:0] lcd_data_oe,
  input wire logic        pixel_clock_wr_pin,
  input wire logic        line_clock_cmd_pin,
  input wire logic        frame_clock_read_pin,
  input wire logic        panel_cs_n,
  input wire logic [7:0]  rd_reply,
  // Pins back to the port
  output logic [7:0]      lcd_data_in,
  output logic            panel_vsync_in,
  // Write log
  output logic [7:0]      wr_byte,
  output logic            wr_data,
  output var logic        wr_tgl = 1'b0
);
  logic [5:0] tmr = 6'h00;
  logic [7:0] idle_pat = 8'hA5;
  // Refresh timer; idle pattern flips so a stale bus never looks valid
  always @(posedge pix_clk) begin
    tmr <= tmr + 6'h01;
    idle_pat <= ~idle_pat;
  end
  assign panel_vsync_in = (tmr < 6'h04);
  // Panel drives only while selected and the port has let go
  assign lcd_data_in = (!panel_cs_n && lcd_data_oe[7:0] == 8'h00) ? rd_reply : idle_pat;
  // Latch at strobe end, data still held in the hold state
  always @(negedge pixel_clock_wr_pin) begin
    if (!panel_cs_n) begin
      wr_byte <= lcd_data_lines[7:0];
      wr_data <= line_clock_cmd_pin;
      wr_tgl <= ~wr_tgl;
    end
  end
endmodule
`default_nettype wire

// File: tb/lasp_port_sva.sv
// Checker for the LCD panel port: raster timing and smart panel strobes.
// Assumes it is bound to lasp_port and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module lasp_port_sva (
  // Clocks and resets
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        pix_clk,
  input wire logic        pix_rst,
  // Handshake and sync
  input wire logic        pix_take,
  input wire logic        refresh_sync,
  input wire logic        panel_vsync_in,
  // Panel pins
  input wire logic [17:0] lcd_data_lines,
  input wire logic [17:0] lcd_data_oe,
  input wire logic        pixel_clock_wr_pin,
  input wire logic        line_clock_cmd_pin,
  input wire logic        frame_clock_read_pin,
  input wire logic        bias_de_pin,
  input wire logic        panel_cs_n
);
  // All lanes enabled only in the active modes
  wire logic act = &lcd_data_oe;

  de_follow_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    pix_take |=> bias_de_pin) else $error("pixel taken without data enable");
  de_stable_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    act && !bias_de_pin ##1 act && !bias_de_pin |-> $stable(lcd_data_lines)) else $error("data moved in blanking");
  hs_pulse_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    act && $rose(line_clock_cmd_pin) |=> !line_clock_cmd_pin) else $error("line sync too long");
  vs_line_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    act && $rose(frame_clock_read_pin) |-> line_clock_cmd_pin) else $error("frame sync off line end");
  wr_cycle_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    $fell(panel_cs_n) && lcd_data_oe[0] |-> !pixel_clock_wr_pin ##1 pixel_clock_wr_pin
    ##1 !pixel_clock_wr_pin && !panel_cs_n ##1 panel_cs_n) else $error("bad write cycle");
  rd_cycle_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    $fell(panel_cs_n) && !lcd_data_oe[0] |-> !panel_cs_n[*2] ##1 panel_cs_n) else $error("bad read cycle");
  low_lanes_a: assert property (@(posedge pix_clk) disable iff (pix_rst)
    !act |-> lcd_data_oe[17:8] == 10'h000) else $error("upper lanes driven");
  sync_path_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(refresh_sync) |-> $past(panel_vsync_in, 2)) else $error("refresh sync not from panel");

  // Main scenarios reached
  cover property (@(posedge pix_clk) act && $rose(frame_clock_read_pin));
  cover property (@(posedge pix_clk) $fell(panel_cs_n) && lcd_data_oe[0]);
  cover property (@(posedge sys_clk) $rose(refresh_sync));
endmodule
bind lasp_port lasp_port_sva chk_u (.sys_clk, .sys_rst, .pix_clk, .pix_rst, .pix_take, .refresh_sync,
  .panel_vsync_in, .lcd_data_lines, .lcd_data_oe, .pixel_clock_wr_pin, .line_clock_cmd_pin,
  .frame_clock_read_pin, .bias_de_pin, .panel_cs_n);
`default_nettype wire

// File: tb/tb_top.sv
// Testbench for the LCD panel port: active rasters, then smart panel traffic.
// Assumes the panel model and the bound checker; link clock runs free.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import lasp_pkg::*;
  logic          sys_clk, sys_rst, sys_ce, pix_clk, pix_rst, alt_data_pin_order, cmd_valid, cmd_is_read;
  lasp_mode_type cfg_mode;
  logic [1:0]    cfg_byte_order;
  logic [11:0]   cfg_h_active, cfg_h_blank, cfg_v_active, cfg_v_blank;
  logic          cmd_is_cmd, cmd_ready, rd_valid, refresh_sync, pix_take, panel_cs_n, panel_vsync_in;
  logic [7:0]    cmd_byte, rd_byte, lcd_data_in, rd_reply, wr_byte, prv, clast, rlast;
  logic [17:0]   pix_data, pv, lcd_data_lines, lcd_data_oe;
  logic          pixel_clock_wr_pin, line_clock_cmd_pin, frame_clock_read_pin, bias_de_pin, wr_data, wr_tgl;
  logic          arm, on, fr, act, m18, alt, smk, have, hs_d, vs_d, cdat;
  logic [17:0]   q[$];
  int            errors, compares, seed, pcnt, hcnt, frames, dcnt, ccnt, rcnt, hact;

  lasp_port dut_u (.sys_clk, .sys_rst, .sys_ce, .cfg_mode, .alt_data_pin_order, .cfg_byte_order, .cfg_h_active,
    .cfg_h_blank, .cfg_v_active, .cfg_v_blank, .cmd_valid, .cmd_is_read, .cmd_is_cmd, .cmd_byte, .cmd_ready,
    .rd_byte, .rd_valid, .refresh_sync, .pix_clk, .pix_rst, .pix_data, .pix_take, .lcd_data_lines, .lcd_data_oe,
    .lcd_data_in, .pixel_clock_wr_pin, .line_clock_cmd_pin, .frame_clock_read_pin, .bias_de_pin, .panel_cs_n,
    .panel_vsync_in);
  lasp_panel_model panel_u (.pix_clk, .lcd_data_lines, .lcd_data_oe, .pixel_clock_wr_pin, .line_clock_cmd_pin,
    .frame_clock_read_pin, .panel_cs_n, .rd_reply, .lcd_data_in, .panel_vsync_in, .wr_byte, .wr_data, .wr_tgl);

  // Clocks, link clock unrelated in phase
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    pix_clk = 1'b0;
    #7;
    forever #16 pix_clk = ~pix_clk;
  end

  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [17:0] s, input logic [17:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // One bounded step of any wait
  task automatic tmo(ref int n);
    @(negedge sys_clk);
    n++;
    if (n > 4000) begin
      errors++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic wait_for(ref int c, input int tgt);
    int n;
    n = 0;
    while (c < tgt) tmo(n);
  endtask
  // Expected panel word; 16-bit keeps colour MSBs on top lanes
  function automatic logic [17:0] exp_px(input logic [17:0] p);
    logic [15:0] w;
    w = {p[17:13], p[11:6], p[5:1]};
    if (alt) w = {w[7:0], w[15:8]};
    exp_px = m18 ? p : {2'h0, w};
  endfunction
  // Byte that must follow b in the chosen colour order
  function automatic logic [7:0] nxt(input logic [7:0] b);
    logic [7:0] c[3];
    logic [7:0] s[3];
    c = '{{pv[17:12], 2'h0}, {pv[11:6], 2'h0}, {pv[5:0], 2'h0}};
    case (cfg_byte_order)
      LASP_ORD_RGB: s = '{c[0], c[1], c[2]};
      LASP_ORD_BGR: s = '{c[2], c[1], c[0]};
      LASP_ORD_GRB: s = '{c[1], c[0], c[2]};
      default: s = '{c[2], c[0], c[1]};
    endcase
    nxt = s[0];
    for (int i = 0; i < 3; i++) if (s[i] == b) nxt = s[(i + 1) % 3];
  endfunction

  // Link side: pixel source, queue of taken pixels, sync counting
  always @(posedge pix_clk) begin
    if (act && pix_take === 1'b1) q.push_back(pix_data);
    if (arm && !on && pix_take === 1'b0 && bias_de_pin === 1'b0) begin
      q.delete();
      on = 1'b1;
    end
    pix_data <= act ? 18'($random(seed)) : pv;
    hs_d <= line_clock_cmd_pin;
    vs_d <= frame_clock_read_pin;
    if (on && line_clock_cmd_pin && !hs_d) hcnt++;
    if (on && frame_clock_read_pin && !vs_d) begin
      if (fr) begin
        check(18'(pcnt), 18'(hact * 4));
        check(18'(hcnt), 18'h6);
        frames++;
      end
      fr = 1'b1;
      pcnt = 0;
      hcnt = 0;
    end
  end
  // Panel samples on its pixel clock only while data enable is high
  always @(posedge pixel_clock_wr_pin) begin
    if (on && bias_de_pin === 1'b1) begin
      pcnt++;
      check(18'(q.size() != 0), 18'h1);
      if (q.size() != 0) check(m18 ? lcd_data_lines : {2'h0, lcd_data_lines[15:0]}, exp_px(q.pop_front()));
    end
  end
  // Smart panel write log; command-path bytes carry nonzero low bits, pixel bytes never do
  always @(wr_tgl) begin
    if (smk && wr_data && wr_byte[1:0] == 2'h0) begin
      if (have) check({10'h0, wr_byte}, {10'h0, nxt(prv)});
      prv = wr_byte;
      have = 1'b1;
      dcnt++;
    end else if (smk) begin
      ccnt++;
      clast = wr_byte;
      cdat = wr_data;
    end
  end
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) begin
      rcnt++;
      rlast = rd_byte;
    end
  end

  task automatic cmd(input logic rd, input logic c, input logic [7:0] b);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) tmo(n);
    @(posedge sys_clk);
    cmd_is_read <= rd;
    cmd_is_cmd <= c;
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic act_run(input lasp_mode_type m, input logic a, input int h);
    arm = 1'b0;
    on = 1'b0;
    fr = 1'b0;
    smk = 1'b0;
    @(posedge sys_clk);
    cfg_mode <= m;
    alt_data_pin_order <= a;
    cfg_h_active <= 12'(h);
    act = 1'b1;
    m18 = (m == LASP_MODE_ACT18);
    alt = a;
    hact = h;
    // Settle the level crossing before checking
    repeat (20) @(posedge sys_clk);
    frames = 0;
    arm = 1'b1;
    wait_for(frames, 3);
    // Park in off mode: a direct switch would drop data enable under a taken pixel
    @(posedge sys_clk);
    cfg_mode <= LASP_MODE_OFF;
    repeat (4) @(posedge sys_clk);
    $display("Active mode %0d alt %0b width %0d done", m, a, h);
  endtask
  task automatic sm_run(input logic [1:0] o);
    logic [5:0] r;
    arm = 1'b0;
    on = 1'b0;
    smk = 1'b0;
    act = 1'b0;
    r = 6'($random(seed));
    pv = {r, r + 6'h1, r + 6'h2};
    @(posedge sys_clk);
    cfg_mode <= LASP_MODE_SMART;
    cfg_byte_order <= o;
    repeat (40) @(posedge sys_clk);
    have = 1'b0;
    dcnt = 0;
    ccnt = 0;
    rcnt = 0;
    smk = 1'b1;
    wait_for(dcnt, 9);
    cmd(1'b0, 1'b1, {r, 2'h1});
    wait_for(ccnt, 1);
    check({10'h0, clast}, {10'h0, r, 2'h1});
    check({17'h0, cdat}, 18'h0);
    cmd(1'b0, 1'b0, {r, 2'h2});
    wait_for(ccnt, 2);
    check({10'h0, clast}, {10'h0, r, 2'h2});
    check({17'h0, cdat}, 18'h1);
    rd_reply = 8'($random(seed));
    cmd(1'b1, 1'b1, 8'h00);
    wait_for(rcnt, 1);
    check({10'h0, rlast}, {10'h0, rd_reply});
    $display("Smart order %0d done", o);
  endtask

  initial begin
    seed = 23;
    {errors, compares, pcnt, hcnt, frames, dcnt, ccnt, rcnt, hact} = '0;
    {arm, on, fr, act, m18, alt, smk, have} = '0;
    sys_rst = 1'b1;
    pix_rst = 1'b1;
    sys_ce = 1'b1;
    cfg_mode = LASP_MODE_OFF;
    {alt_data_pin_order, cmd_valid, cmd_is_read, cmd_is_cmd} = '0;
    cfg_byte_order = 2'h0;
    {cfg_h_active, cfg_h_blank, cfg_v_active, cfg_v_blank} = {12'h008, 12'h004, 12'h004, 12'h002};
    cmd_byte = 8'h00;
    rd_reply = 8'h00;
    pix_data = 18'h00000;
    pv = 18'h00000;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge pix_clk);
    pix_rst <= 1'b0;
    act_run(LASP_MODE_ACT16, 1'b0, 8);
    act_run(LASP_MODE_ACT16, 1'b1, 1);
    act_run(LASP_MODE_ACT18, 1'b0, 6);
    for (int o = 0; o < 4; o++) sm_run(2'(o));
    give_verdict();
  end
endmodule
`default_nettype wire
